/* File: rtl/mpp_pkg.sv */
// constants and types shared by the port pin logic and its transmit fifo
// assumes a 200 MHz core clock and a plain mode input, no register bus
package mpp_pkg;

  // ------------------------------------------------------------------
  // widths and depths
  // ------------------------------------------------------------------
  localparam int NIBBLE_W = 4;
  localparam int FIFO_W = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int LAST_BIT = 4;

  // ------------------------------------------------------------------
  // interface modes
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_MII = 2'h0;
  localparam logic [1:0] MODE_SMII = 2'h1;
  localparam logic [1:0] MODE_SS = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 5;
  localparam int SS_TX_CLK_PERIOD_NS = 8;
  // longest half period, rounded down, never below one cycle
  localparam int SS_HALF_CYCLES_INT = ((SS_TX_CLK_PERIOD_NS / 2) / SYS_CLK_PERIOD_NS > 0) ?
    ((SS_TX_CLK_PERIOD_NS / 2) / SYS_CLK_PERIOD_NS) : 1;
  localparam logic [3:0] SS_HALF_CYCLES = 4'(SS_HALF_CYCLES_INT);

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] NIBBLE_IDLE = 4'h0;
  localparam logic [3:0] DIV_RESET = 4'h0;

  // ------------------------------------------------------------------
  // transmit frame states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_FRAME = 2'b10
  } mpp_tx_state_e;

endpackage : mpp_pkg

/* File: rtl/mpp_fifo.sv */
// transmit fifo, flip-flop storage, registered flags
// assumes a single clock domain and a freeze enable from the parent
module mpp_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic notFull_q, notFull_d, notEmpty_q, notEmpty_d;
  logic push, pop;

  function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
    nextPtr = (p == PTR_LAST) ? '0 : PTR_W'(p + 1'b1);
  endfunction : nextPtr

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    push = inValid && notFull_q;
    pop = outReady && notEmpty_q;
    wrPtr_d = push ? nextPtr(wrPtr_q) : wrPtr_q;
    rdPtr_d = pop ? nextPtr(rdPtr_q) : rdPtr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = CNT_W'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_d = CNT_W'(count_q - 1'b1);
    end
    notFull_d = (count_d != CNT_FULL);
    notEmpty_d = (count_d != '0);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      notFull_q <= 1'b1;
      notEmpty_q <= 1'b0;
    end else if (clockEnable) begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      notFull_q <= notFull_d;
      notEmpty_q <= notEmpty_d;
    end
  end

  // storage needs no reset, reads are masked by the empty flag
  always_ff @(posedge clock) begin
    if (clockEnable && push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  assign inReady = notFull_q;
  assign outValid = notEmpty_q;
  assign outData = mem_q[rdPtr_q];

  fifo_bound_a: assert property (@(posedge clock) disable iff (!reset_n)
    count_q <= CNT_FULL && (notFull_q == (count_q != CNT_FULL)))
    else $error("fifo count out of range");

endmodule : mpp_fifo

/* File: rtl/mpp_port.sv */
// pin logic of one mac port: 4-bit mii or four serial lanes, plain or source-synchronous
// assumes link clocks arrive on pins and are oversampled by the 200 MHz core clock
module mpp_port (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // configuration
  input wire logic [1:0] modeSel,
  input wire logic portEnable,
  // transmit stream
  input wire logic txValid,
  input wire logic [3:0] txData,
  input wire logic txLast,
  output logic txReady,
  // receive samples and status
  output logic [3:0] rxSample,
  output logic rxSampleValid,
  output logic rxSyncSeen,
  output logic txUnderrun,
  // link pins
  input wire logic miiTxClockIn,
  input wire logic miiRxClockIn,
  input wire logic ssRxSyncPulse,
  input wire logic [3:0] rxDataIn,
  output logic [3:0] miiTxNibble,
  output logic miiTxEnable
);

  logic [1:0] mode_q, mode_d;
  mpp_pkg::mpp_tx_state_e state_q, state_d;
  logic [3:0] txNibble_q, txNibble_d;
  logic txPin_q, txPin_d;
  logic ssPhase_q, ssPhase_d;
  logic [3:0] divCnt_q, divCnt_d;
  logic underrun_q, underrun_d;
  logic [3:0] rxSample_q, rxSample_d;
  logic rxValid_q, rxValid_d, rxSyncSeen_q, rxSyncSeen_d;
  logic txReady_q;
  logic txClkMeta_q, txClkSync_q, txClkPrev_q;
  logic rxClkMeta_q, rxClkSync_q, rxClkPrev_q;
  logic syncMeta_q, syncSync_q;
  logic [3:0] rxDataMeta_q, rxDataSync_q;
  logic txClkRise, rxClkRise, ssRise, launch, rxEdge;
  logic fifoValid, fifoPop, fifoReady;
  logic [mpp_pkg::FIFO_W-1:0] fifoData;

  function automatic logic risingEdge(input logic cur, input logic prev);
    risingEdge = cur && !prev;
  endfunction : risingEdge

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  // clocks and data share the same two-stage latency, so sample edges stay aligned
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txClkMeta_q <= 1'b0;
      txClkSync_q <= 1'b0;
      txClkPrev_q <= 1'b0;
      rxClkMeta_q <= 1'b0;
      rxClkSync_q <= 1'b0;
      rxClkPrev_q <= 1'b0;
      syncMeta_q <= 1'b0;
      syncSync_q <= 1'b0;
      rxDataMeta_q <= mpp_pkg::NIBBLE_IDLE;
      rxDataSync_q <= mpp_pkg::NIBBLE_IDLE;
    end else if (clockEnable) begin
      txClkMeta_q <= miiTxClockIn;
      txClkSync_q <= txClkMeta_q;
      txClkPrev_q <= txClkSync_q;
      rxClkMeta_q <= miiRxClockIn;
      rxClkSync_q <= rxClkMeta_q;
      rxClkPrev_q <= rxClkSync_q;
      syncMeta_q <= ssRxSyncPulse;
      syncSync_q <= syncMeta_q;
      rxDataMeta_q <= rxDataIn;
      rxDataSync_q <= rxDataMeta_q;
    end
  end

  // ------------------------------------------------------------------
  // transmit fifo
  // ------------------------------------------------------------------
  mpp_fifo #(
    .WIDTH(mpp_pkg::FIFO_W),
    .DEPTH(mpp_pkg::FIFO_DEPTH)
  ) txFifo (
    .clock(clock),
    .reset_n(reset_n),
    .clockEnable(clockEnable),
    .inValid(txValid),
    .inData({txLast, txData}),
    .inReady(fifoReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(fifoPop)
  );

  // ------------------------------------------------------------------
  // transmit next state
  // ------------------------------------------------------------------
  // core clock caps the generated clock at half its rate: a limitation at 200 MHz
  always_comb begin
    mode_d = portEnable ? mode_q : modeSel;
    txClkRise = risingEdge(txClkSync_q, txClkPrev_q);
    divCnt_d = mpp_mode_ss() ? 4'(divCnt_q + 1'b1) : mpp_pkg::DIV_RESET;
    ssPhase_d = 1'b0;
    if (mpp_mode_ss()) begin
      ssPhase_d = ssPhase_q;
      if (divCnt_d >= mpp_pkg::SS_HALF_CYCLES) begin
        divCnt_d = mpp_pkg::DIV_RESET;
        ssPhase_d = !ssPhase_q;
      end
    end
    ssRise = risingEdge(ssPhase_d, ssPhase_q);
    // serial modes launch on the reference or on our own clock
    launch = mpp_mode_ss() ? ssRise : txClkRise;
    fifoPop = portEnable && launch;
    txNibble_d = txNibble_q;
    state_d = state_q;
    underrun_d = underrun_q && portEnable;
    txPin_d = 1'b0;
    if (!portEnable) begin
      txNibble_d = mpp_pkg::NIBBLE_IDLE;
      state_d = mpp_pkg::TX_IDLE;
    end else begin
      if (mode_q == mpp_pkg::MODE_MII) begin
        txPin_d = txPin_q;
      end
      if (launch) begin
        case (state_q)
          mpp_pkg::TX_IDLE, mpp_pkg::TX_FRAME: begin
            if (fifoValid) begin
              // lane n takes word bit n in every mode
              txNibble_d = fifoData[mpp_pkg::NIBBLE_W-1:0];
              txPin_d = (mode_q == mpp_pkg::MODE_MII);
              state_d = fifoData[mpp_pkg::LAST_BIT] ? mpp_pkg::TX_IDLE : mpp_pkg::TX_FRAME;
            end else begin
              txNibble_d = mpp_pkg::NIBBLE_IDLE;
              txPin_d = 1'b0;
              underrun_d = underrun_q || (state_q == mpp_pkg::TX_FRAME);
              state_d = mpp_pkg::TX_IDLE;
            end
          end
          default: begin
            state_d = mpp_pkg::TX_IDLE;
          end
        endcase
      end
      if (mpp_mode_ss()) begin
        txPin_d = ssPhase_d;
      end
    end
  end

  function automatic logic mpp_mode_ss();
    mpp_mode_ss = portEnable && (mode_q == mpp_pkg::MODE_SS);
  endfunction : mpp_mode_ss

  // ------------------------------------------------------------------
  // receive next state
  // ------------------------------------------------------------------
  always_comb begin
    rxClkRise = risingEdge(rxClkSync_q, rxClkPrev_q);
    // plain serial receives on the reference, others on the phy receive clock
    rxEdge = (mode_q == mpp_pkg::MODE_SMII) ? txClkRise : rxClkRise;
    rxSample_d = rxSample_q;
    rxValid_d = 1'b0;
    rxSyncSeen_d = 1'b0;
    if (portEnable && rxEdge) begin
      rxSample_d = rxDataSync_q;
      rxValid_d = 1'b1;
      rxSyncSeen_d = syncSync_q && (mode_q == mpp_pkg::MODE_SS);
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= mpp_pkg::MODE_RESET;
      state_q <= mpp_pkg::TX_IDLE;
      txNibble_q <= mpp_pkg::NIBBLE_IDLE;
      txPin_q <= 1'b0;
      ssPhase_q <= 1'b0;
      divCnt_q <= mpp_pkg::DIV_RESET;
      underrun_q <= 1'b0;
      rxSample_q <= mpp_pkg::NIBBLE_IDLE;
      rxValid_q <= 1'b0;
      rxSyncSeen_q <= 1'b0;
      txReady_q <= 1'b0;
    end else if (clockEnable) begin
      mode_q <= mode_d;
      state_q <= state_d;
      txNibble_q <= txNibble_d;
      txPin_q <= txPin_d;
      ssPhase_q <= ssPhase_d;
      divCnt_q <= divCnt_d;
      underrun_q <= underrun_d;
      rxSample_q <= rxSample_d;
      rxValid_q <= rxValid_d;
      rxSyncSeen_q <= rxSyncSeen_d;
      txReady_q <= 1'b1;
    end
  end

  assign txReady = fifoReady && txReady_q;
  assign miiTxNibble = txNibble_q;
  assign miiTxEnable = txPin_q;
  assign rxSample = rxSample_q;
  assign rxSampleValid = rxValid_q;
  assign rxSyncSeen = rxSyncSeen_q;
  assign txUnderrun = underrun_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  mii_launch_a: assert property (@(posedge clock) disable iff (!reset_n)
    ($changed(txNibble_q) && $past(portEnable) && portEnable && mode_q == mpp_pkg::MODE_MII)
    |-> $past(txClkRise))
    else $error("mii nibble changed without a transmit clock edge");

  ref_launch_a: assert property (@(posedge clock) disable iff (!reset_n)
    ($changed(txNibble_q) && $past(portEnable) && portEnable && mode_q == mpp_pkg::MODE_SMII)
    |-> $past(txClkRise))
    else $error("serial lanes changed off the reference edge");

  ss_launch_a: assert property (@(posedge clock) disable iff (!reset_n)
    ($changed(txNibble_q) && $past(portEnable) && portEnable && mode_q == mpp_pkg::MODE_SS)
    |-> $rose(txPin_q))
    else $error("source-synchronous data changed off own clock edge");

  ss_clock_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && portEnable && mode_q == mpp_pkg::MODE_SS && $past(mpp_mode_ss()))
    ##1 (clockEnable && portEnable) |-> txPin_q != $past(txPin_q))
    else $error("transmit clock did not toggle");

  lane_map_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && fifoPop && fifoValid) |=> txNibble_q == $past(fifoData[3:0]))
    else $error("lane bit not taken from matching word bit");

  tx_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode_q == mpp_pkg::MODE_MII && portEnable && $rose(txPin_q))
    |-> $past(fifoPop && fifoValid))
    else $error("transmit enable rose without a nibble");

  rx_sample_a: assert property (@(posedge clock) disable iff (!reset_n)
    (rxValid_q && $past(clockEnable) && mode_q != mpp_pkg::MODE_SMII)
    |-> $past(rxClkRise && portEnable))
    else $error("receive sample without receive clock edge");

  mode_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    ($past(portEnable) && portEnable) |-> $stable(mode_q))
    else $error("mode changed while enabled");

endmodule : mpp_port

/* File: dv/mpp_phy_model.sv */
// phy side of the port: free-running link clocks, receive data and sync pulse
// assumes the bench samples the transmit pins itself
module mpp_phy_model (
  // link pins toward the port
  output logic miiTxClockIn,
  output logic miiRxClockIn,
  output logic ssRxSyncPulse,
  output logic [3:0] rxDataIn,
  // value present at the last receive clock rise
  output logic [3:0] rxExpect
);
  timeunit 1ns;
  timeprecision 100ps;
  int rxCount = 0;
  initial begin
    miiTxClockIn = 1'b0;
    miiRxClockIn = 1'b0;
    ssRxSyncPulse = 1'b0;
    rxDataIn = 4'h3;
    rxExpect = 4'h0;
  end
  // -------------------------------------------------------------
  // clocks: odd start offsets keep them off the core clock edges
  // -------------------------------------------------------------
  initial begin
    #3.1;
    forever #62.5 miiTxClockIn = ~miiTxClockIn;
  end
  initial begin
    #17.3;
    forever #62.5 miiRxClockIn = ~miiRxClockIn;
  end
  // -------------------------------------------------------------
  // receive data changes on the falling edge, pattern never repeats twice
  // -------------------------------------------------------------
  always @(posedge miiRxClockIn) begin
    rxExpect = rxDataIn;
  end
  always @(negedge miiRxClockIn) begin
    rxDataIn <= rxDataIn + 4'h5;
    rxCount <= (rxCount == 9) ? 0 : rxCount + 1;
    ssRxSyncPulse <= (rxCount == 9);
  end
endmodule : mpp_phy_model

/* File: dv/tb_mpp_port.sv */
// self-checking bench for the port pin logic in all three modes
// assumes the phy model drives every link pin
module tb_mpp_port;
  timeunit 1ns;
  timeprecision 100ps;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clockEnable = 1'b1;
  logic [1:0] modeSel = mpp_pkg::MODE_MII;
  logic portEnable = 1'b0;
  logic txValid = 1'b0;
  logic [3:0] txData = 4'h0;
  logic txLast = 1'b0;
  logic txReady, rxSampleValid, rxSyncSeen, txUnderrun, miiTxEnable;
  logic miiTxClockIn, miiRxClockIn, ssRxSyncPulse;
  logic [3:0] rxSample, rxDataIn, miiTxNibble, rxExpect;
  logic [3:0] sentQ[$];
  logic [3:0] capQ[$];
  logic capOn = 1'b0;
  logic ssOn = 1'b0;
  logic rxOn = 1'b0;
  logic [3:0] prevNib = 4'h0;
  logic prevEn = 1'b0;
  int errors = 0;
  int n_compared = 0;
  int nValid = 0;
  int nSync = 0;
  always #2.5 clock = ~clock;
  mpp_port dut (.clock(clock), .reset_n(reset_n), .clockEnable(clockEnable),
    .modeSel(modeSel), .portEnable(portEnable), .txValid(txValid), .txData(txData),
    .txLast(txLast), .txReady(txReady), .rxSample(rxSample), .rxSampleValid(rxSampleValid),
    .rxSyncSeen(rxSyncSeen), .txUnderrun(txUnderrun), .miiTxClockIn(miiTxClockIn),
    .miiRxClockIn(miiRxClockIn), .ssRxSyncPulse(ssRxSyncPulse), .rxDataIn(rxDataIn),
    .miiTxNibble(miiTxNibble), .miiTxEnable(miiTxEnable));
  mpp_phy_model phy (.miiTxClockIn(miiTxClockIn), .miiRxClockIn(miiRxClockIn),
    .ssRxSyncPulse(ssRxSyncPulse), .rxDataIn(rxDataIn), .rxExpect(rxExpect));
  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask : cycles
  // task lowers txValid itself after the last word, each word held until txReady
  task automatic sendFrame(input int n, input logic endIt);
    int i;
    int k;
    for (k = 0; k < n; k++) begin
      txValid <= 1'b1;
      txData <= 4'($urandom_range(15, 1));
      txLast <= endIt && (k == n - 1);
      for (i = 0; i < 400; i++) begin
        @(posedge clock);
        if (txReady === 1'b1) break;
      end
      if (i == 400) begin
        errors++;
        complete_run();
      end
      sentQ.push_back(txData);
    end
    txValid <= 1'b0;
  endtask : sendFrame
  task automatic checkFrame();
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clock);
      if (capQ.size() >= sentQ.size()) break;
    end
    if (i == 3000) begin
      errors++;
      complete_run();
    end
    cycles(60);
    chk(8'(capQ.size()), 8'(sentQ.size()));
    for (i = 0; i < capQ.size() && i < sentQ.size(); i++) begin
      chk(capQ[i], sentQ[i]);
    end
    capQ.delete();
    sentQ.delete();
  endtask : checkFrame
  task automatic setMode(input logic [1:0] m);
    portEnable <= 1'b0;
    cycles(2);
    modeSel <= m;
    cycles(2);
  endtask : setMode
  // -------------------------------------------------------------
  // monitors: mii and plain serial pins sampled at the phy transmit clock rise, source-synchronous pins on the core clock
  // -------------------------------------------------------------
  always @(posedge miiTxClockIn) begin
    if (capOn && modeSel == mpp_pkg::MODE_MII && miiTxEnable === 1'b1) begin
      capQ.push_back(miiTxNibble);
    end
    if (capOn && modeSel == mpp_pkg::MODE_SMII && miiTxNibble !== 4'h0) begin
      capQ.push_back(miiTxNibble);
      chk(miiTxEnable, 1'b0);
    end
  end
  always @(posedge clock) begin
    if (ssOn) begin
      chk(miiTxEnable, !prevEn);
      if (miiTxNibble !== prevNib) chk({prevEn, miiTxEnable}, 2'b01);
      if (!prevEn && miiTxEnable === 1'b1 && miiTxNibble !== 4'h0) capQ.push_back(miiTxNibble);
    end
    if (rxOn && rxSampleValid === 1'b1) begin
      chk(rxSample, rxExpect);
      nValid++;
    end
    if (rxOn && modeSel == mpp_pkg::MODE_MII) chk(rxSyncSeen, 1'b0);
    if (rxOn && modeSel == mpp_pkg::MODE_SS && rxSyncSeen === 1'b1) begin
      if (nSync > 0) chk(8'(nValid), 8'd10);
      nValid = 0;
      nSync++;
    end
    prevEn <= miiTxEnable;
    prevNib <= miiTxNibble;
  end
  initial begin
    cycles(100000);
    errors++;
    complete_run();
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    int i;
    int n;
    void'($urandom(32'h466016a4));
    cycles(16);
    chk({txReady, txUnderrun, miiTxEnable, miiTxNibble}, 8'h00);
    reset_n <= 1'b1;
    cycles(2);
    // fill while disabled: the fifo must hold its words, pins idle
    n = 0;
    for (i = 0; i < 12; i++) begin
      txValid <= 1'b1;
      txData <= 4'($urandom_range(15, 1));
      txLast <= (i == 7);
      @(posedge clock);
      if (txReady === 1'b1) begin
        n++;
        sentQ.push_back(txData);
      end
    end
    txValid <= 1'b0;
    chk(8'(n), 8'(mpp_pkg::FIFO_DEPTH));
    chk(miiTxEnable, 1'b0);
    portEnable <= 1'b1;
    capOn <= 1'b1;
    rxOn <= 1'b1;
    checkFrame();
    chk({miiTxEnable, txUnderrun}, 2'b00);
    sendFrame($urandom_range(6, 2), 1'b1);
    checkFrame();
    // a mode change while running must be ignored
    modeSel <= mpp_pkg::MODE_SS;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      chk(miiTxEnable, 1'b0);
    end
    modeSel <= mpp_pkg::MODE_MII;
    // frame without an end runs dry
    sendFrame(3, 1'b0);
    for (i = 0; i < 400 && txUnderrun !== 1'b1; i++) cycles(1);
    chk({txUnderrun, miiTxEnable}, 2'b10);
    checkFrame();
    rxOn <= 1'b0;
    setMode(mpp_pkg::MODE_SMII);
    chk(txUnderrun, 1'b0);
    portEnable <= 1'b1;
    sendFrame(5, 1'b1);
    checkFrame();
    setMode(mpp_pkg::MODE_SS);
    portEnable <= 1'b1;
    cycles(4);
    ssOn <= 1'b1;
    rxOn <= 1'b1;
    sendFrame(4, 1'b1);
    cycles(2000);
    ssOn <= 1'b0;
    rxOn <= 1'b0;
    chk(8'(nSync > 2), 8'd1);
    // a low clock enable must freeze the generated clock
    clockEnable <= 1'b0;
    cycles(2);
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      chk(miiTxEnable, prevEn);
    end
    clockEnable <= 1'b1;
    checkFrame();
    complete_run();
  end
endmodule : tb_mpp_port
